// ==== logic/hsg_clk_if.sv ====
// haptic clock enable and its rate family, shared by the generator's own modules
// assumes: one clock domain; tick is a one-cycle enable
`timescale 1ns/100ps
interface hsg_clk_if;
	logic fam_44k;
	logic tick;
	modport ctl(output fam_44k, input tick);
	modport gen(input fam_44k, output tick);
	modport snk(input tick);
endinterface

// ==== logic/hsg_half_period.sv ====
// half-period counter of the resonant tone: flips every divider+1 haptic ticks
// assumes: en_i low parks the tone at its first half
`timescale 1ns/100ps
module hsg_half_period #(
	parameter int DIV_W = 15
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic en_i,
	input wire logic [DIV_W-1:0] div_i,
	hsg_clk_if.snk clk_if,
	output logic half_o
);
	logic [DIV_W-1:0] cnt_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r <= '0;
			half_o <= 1'b0;
		end else if (!en_i) begin
			cnt_r <= div_i;
			half_o <= 1'b0;
		end else if (clk_if.tick) begin
			if (cnt_r == '0) begin
				cnt_r <= div_i;
				half_o <= !half_o;
			end else begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end
	half_flip_a: assert property (@(posedge clk_i) disable iff (rst_i)
		en_i && clk_if.tick && cnt_r == '0 |=> half_o != $past(half_o) && cnt_r == $past(div_i))
		else $error("tone half did not flip on reload");
endmodule // hsg_half_period

// ==== logic/hsg_haptic_gen.sv ====
// top of the haptic signal generator: registers, one-shot sequencer, sample output
// assumes: plain register port with read data one cycle after the strobe,
// clock-family pins come from outside the clock domain
//
// What this block does
// - writing one to the trigger bit starts the profile: phase 1, 2, 3
// - mode field: 00 off, 01 continuous, 10 one-shot, 11 reserved
// - actuator select: zero gives dc output, one gives ac output
// - ac frequency is haptic clock over twice (divider plus one)
// - haptic clock from main clock below rate 1000, async clock otherwise
// - divider has no effect while the rotating-mass actuator is chosen
// - phase levels are eight-bit two's complement spanning full scale
// - rotating-mass output is the active level held as dc
// - resonant output peak is the level; negative level inverts the wave
// - phase 1 lasts its nine-bit length times 0.625 ms
// - phase 2 lasts its eleven-bit length times 0.625 ms
// - phase 3 lasts its nine-bit length times 0.625 ms
// - a zero length skips its phase straight to the next one
// - continuous mode plays the phase 2 level; lengths unused
// - busy bit reads one while a one-shot profile runs
// - mixer input carries the haptic stream when source code is 06h
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`include "hsg_map.svh"
module hsg_haptic_gen #(
	parameter logic [11:0] STEP_TICKS_48K = 12'(`HSG_STEP_TICKS_48K),
	parameter logic [11:0] STEP_TICKS_44K = 12'(`HSG_STEP_TICKS_44K)
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	input wire logic main_clk_44k1_i,
	input wire logic async_clk_44k1_i,
	input wire logic [7:0] mixer_source_select_i,
	output logic [23:0] hap_sample_o,
	output logic hap_sample_valid_o,
	output logic [23:0] mix_sample_o,
	output logic single_pulse_busy_o,
	output logic irq_o
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	hsg_pkg::hsg_mode_e mode_r;
	logic act_r;
	logic [14:0] div_r;
	logic [7:0] lvl1_r;
	logic [7:0] lvl2_r;
	logic [7:0] lvl3_r;
	logic [8:0] len1_r;
	logic [10:0] len2_r;
	logic [8:0] len3_r;
	logic [3:0] rate_r;
	logic [1:0] irq_sts_r;
	logic [1:0] irq_mask_r;
	logic trig_wr;

	assign trig_wr = reg_wr_i && reg_addr_i == `HSG_CTRL_OFS && reg_wdata_i[`HSG_TRIG_BIT];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_r <= hsg_pkg::HSG_MODE_OFF;
			act_r <= 1'b0;
			div_r <= `HSG_DIV_RST;
			lvl1_r <= `HSG_LVL_RST;
			lvl2_r <= `HSG_LVL_RST;
			lvl3_r <= `HSG_LVL_RST;
			len1_r <= `HSG_LEN_SHORT_RST;
			len2_r <= `HSG_LEN_LONG_RST;
			len3_r <= `HSG_LEN_SHORT_RST;
			rate_r <= `HSG_RATE_RST;
			irq_mask_r <= `HSG_IRQ_RST;
		end else if (reg_wr_i) begin
			if (reg_addr_i == `HSG_CTRL_OFS) begin
				mode_r <= hsg_pkg::hsg_mode_e'(reg_wdata_i[`HSG_MODE_LSB +: 2]);
				act_r <= reg_wdata_i[`HSG_ACT_BIT];
			end else if (reg_addr_i == `HSG_DIV_OFS) begin
				div_r <= reg_wdata_i[14:0];
			end else if (reg_addr_i == `HSG_LVL1_OFS) begin
				lvl1_r <= reg_wdata_i[7:0];
			end else if (reg_addr_i == `HSG_LEN1_OFS) begin
				len1_r <= reg_wdata_i[8:0];
			end else if (reg_addr_i == `HSG_LVL2_OFS) begin
				lvl2_r <= reg_wdata_i[7:0];
			end else if (reg_addr_i == `HSG_LEN2_OFS) begin
				len2_r <= reg_wdata_i[10:0];
			end else if (reg_addr_i == `HSG_LVL3_OFS) begin
				lvl3_r <= reg_wdata_i[7:0];
			end else if (reg_addr_i == `HSG_LEN3_OFS) begin
				len3_r <= reg_wdata_i[8:0];
			end else if (reg_addr_i == `HSG_RATE_OFS) begin
				rate_r <= reg_wdata_i[3:0];
			end else if (reg_addr_i == `HSG_IRQ_MASK_OFS) begin
				irq_mask_r <= reg_wdata_i[1:0];
			end
		end
	end

	// ----------------------------------------
	// clock source selection
	// ----------------------------------------
	// bit 0 main clock family, bit 1 async clock family
	logic [1:0] fam_s1_r;
	logic [1:0] fam_s2_r;
	logic [1:0] fam_s3_r;
	logic [1:0] fam_r;
	logic [11:0] step_max;
	hsg_clk_if clk_if();

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fam_s1_r <= 2'h0;
			fam_s2_r <= 2'h0;
			fam_s3_r <= 2'h0;
			fam_r <= 2'h0;
		end else begin
			fam_s1_r <= {async_clk_44k1_i, main_clk_44k1_i};
			fam_s2_r <= fam_s1_r;
			fam_s3_r <= fam_s2_r;
			// a bit moves only once the last two stages agree
			fam_r <= ((fam_s2_r ~^ fam_s3_r) & fam_s3_r) | ((fam_s2_r ^ fam_s3_r) & fam_r);
		end
	end

	assign clk_if.fam_44k = (rate_r >= `HSG_RATE_ASYNC_MIN) ? fam_r[1] : fam_r[0];
	assign step_max = clk_if.fam_44k ? STEP_TICKS_44K : STEP_TICKS_48K;

	hsg_rate_tick u_rate (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clk_if(clk_if.gen)
	);

	// ----------------------------------------
	// one-shot sequencer
	// ----------------------------------------
	hsg_pkg::hsg_state_e state_r;
	hsg_pkg::hsg_state_e state_nxt;
	hsg_pkg::hsg_state_e succ;
	logic [10:0] succ_len;
	logic [10:0] len_cur;
	logic [10:0] rem_r;
	logic [10:0] rem_nxt;
	logic [11:0] step_r;
	logic step_end;
	logic busy;
	logic done_evt;
	logic refused_evt;

	assign busy = state_r != hsg_pkg::HSG_ST_IDLE;
	assign step_end = busy && clk_if.tick && step_r == step_max - 12'h001;
	assign refused_evt = trig_wr && (mode_r != hsg_pkg::HSG_MODE_ONESHOT || busy);

	// next non-empty phase after the current one
	always_comb begin
		succ = hsg_pkg::HSG_ST_IDLE;
		case (state_r)
			hsg_pkg::HSG_ST_IDLE: begin
				if (len1_r != 9'h000) begin
					succ = hsg_pkg::HSG_ST_PH1;
				end else if (len2_r != 11'h000) begin
					succ = hsg_pkg::HSG_ST_PH2;
				end else if (len3_r != 9'h000) begin
					succ = hsg_pkg::HSG_ST_PH3;
				end
			end
			hsg_pkg::HSG_ST_PH1: begin
				if (len2_r != 11'h000) begin
					succ = hsg_pkg::HSG_ST_PH2;
				end else if (len3_r != 9'h000) begin
					succ = hsg_pkg::HSG_ST_PH3;
				end
			end
			hsg_pkg::HSG_ST_PH2: begin
				if (len3_r != 9'h000) begin
					succ = hsg_pkg::HSG_ST_PH3;
				end
			end
			default: begin
				succ = hsg_pkg::HSG_ST_IDLE;
			end
		endcase
		case (succ)
			hsg_pkg::HSG_ST_PH1: succ_len = {2'h0, len1_r};
			hsg_pkg::HSG_ST_PH2: succ_len = len2_r;
			hsg_pkg::HSG_ST_PH3: succ_len = {2'h0, len3_r};
			default: succ_len = 11'h000;
		endcase
		case (state_r)
			hsg_pkg::HSG_ST_PH1: len_cur = {2'h0, len1_r};
			hsg_pkg::HSG_ST_PH2: len_cur = len2_r;
			hsg_pkg::HSG_ST_PH3: len_cur = {2'h0, len3_r};
			default: len_cur = 11'h000;
		endcase
	end

	always_comb begin
		state_nxt = state_r;
		rem_nxt = rem_r;
		done_evt = 1'b0;
		if (mode_r != hsg_pkg::HSG_MODE_ONESHOT) begin
			state_nxt = hsg_pkg::HSG_ST_IDLE;
			rem_nxt = 11'h000;
		end else if (!busy) begin
			if (trig_wr) begin
				state_nxt = succ;
				rem_nxt = succ_len;
				done_evt = succ == hsg_pkg::HSG_ST_IDLE;
			end
		end else if (step_end) begin
			if (rem_r == 11'h001) begin
				state_nxt = succ;
				rem_nxt = succ_len;
				done_evt = succ == hsg_pkg::HSG_ST_IDLE;
			end else begin
				rem_nxt = rem_r - 11'h001;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= hsg_pkg::HSG_ST_IDLE;
			rem_r <= 11'h000;
		end else begin
			state_r <= state_nxt;
			rem_r <= rem_nxt;
		end
	end

	// step of 0.625 ms counted in haptic ticks, restarted at every phase entry
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			step_r <= 12'h000;
		end else if (state_nxt != state_r || !busy) begin
			step_r <= 12'h000;
		end else if (clk_if.tick) begin
			step_r <= step_end ? 12'h000 : step_r + 12'h001;
		end
	end

	// ----------------------------------------
	// sample path
	// ----------------------------------------
	logic [7:0] level_sel;
	logic [23:0] pos_val;
	logic [23:0] neg_val;
	logic [23:0] sample_nxt;
	logic half;

	always_comb begin
		level_sel = 8'h00;
		if (mode_r == hsg_pkg::HSG_MODE_CONT) begin
			level_sel = lvl2_r;
		end else if (mode_r == hsg_pkg::HSG_MODE_ONESHOT) begin
			case (state_r)
				hsg_pkg::HSG_ST_PH1: level_sel = lvl1_r;
				hsg_pkg::HSG_ST_PH2: level_sel = lvl2_r;
				hsg_pkg::HSG_ST_PH3: level_sel = lvl3_r;
				default: level_sel = 8'h00;
			endcase
		end
	end

	// level is the top byte of the signed core word; -fs inverted saturates
	assign pos_val = {level_sel, 16'h0000};
	assign neg_val = (level_sel == 8'h80) ? 24'h7fffff : 24'(~pos_val + 24'h000001);
	assign sample_nxt = act_r ? (half ? neg_val : pos_val) : pos_val;

	hsg_half_period #(
		.DIV_W(15)
	) u_half (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.en_i(act_r && mode_r != hsg_pkg::HSG_MODE_OFF),
		.div_i(div_r),
		.clk_if(clk_if.snk),
		.half_o(half)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hap_sample_o <= 24'h000000;
			mix_sample_o <= 24'h000000;
			hap_sample_valid_o <= 1'b0;
		end else begin
			hap_sample_valid_o <= clk_if.tick;
			if (clk_if.tick) begin
				hap_sample_o <= sample_nxt;
				mix_sample_o <= (mixer_source_select_i == `HSG_MIX_SRC_CODE) ? sample_nxt : 24'h000000;
			end
		end
	end

	// ----------------------------------------
	// interrupt and read-back
	// ----------------------------------------
	logic irq_rd;

	assign irq_rd = reg_rd_i && reg_addr_i == `HSG_IRQ_STS_OFS;
	assign single_pulse_busy_o = busy;
	assign irq_o = |(irq_sts_r & irq_mask_r);

	// a new event in the clearing read's cycle survives the clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_sts_r <= `HSG_IRQ_RST;
		end else begin
			irq_sts_r <= (irq_rd ? 2'h0 : irq_sts_r) | {refused_evt, done_evt};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reg_rdata_o <= 16'h0000;
		end else if (reg_rd_i) begin
			if (reg_addr_i == `HSG_CTRL_OFS) begin
				reg_rdata_o <= {12'h000, mode_r, act_r, 1'b0};
			end else if (reg_addr_i == `HSG_DIV_OFS) begin
				reg_rdata_o <= {1'b0, div_r};
			end else if (reg_addr_i == `HSG_LVL1_OFS) begin
				reg_rdata_o <= {8'h00, lvl1_r};
			end else if (reg_addr_i == `HSG_LEN1_OFS) begin
				reg_rdata_o <= {7'h00, len1_r};
			end else if (reg_addr_i == `HSG_LVL2_OFS) begin
				reg_rdata_o <= {8'h00, lvl2_r};
			end else if (reg_addr_i == `HSG_LEN2_OFS) begin
				reg_rdata_o <= {5'h00, len2_r};
			end else if (reg_addr_i == `HSG_LVL3_OFS) begin
				reg_rdata_o <= {8'h00, lvl3_r};
			end else if (reg_addr_i == `HSG_LEN3_OFS) begin
				reg_rdata_o <= {7'h00, len3_r};
			end else if (reg_addr_i == `HSG_STS_OFS) begin
				reg_rdata_o <= {15'h0000, busy};
			end else if (reg_addr_i == `HSG_RATE_OFS) begin
				reg_rdata_o <= {12'h000, rate_r};
			end else if (reg_addr_i == `HSG_IRQ_STS_OFS) begin
				reg_rdata_o <= {14'h0000, irq_sts_r};
			end else if (reg_addr_i == `HSG_IRQ_MASK_OFS) begin
				reg_rdata_o <= {14'h0000, irq_mask_r};
			end else begin
				reg_rdata_o <= 16'h0000;
			end
		end else begin
			reg_rdata_o <= 16'h0000;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	logic [11:0] el_cnt_r;
	logic phase_exit;

	assign phase_exit = busy && state_nxt != state_r && mode_r == hsg_pkg::HSG_MODE_ONESHOT;

	always_ff @(posedge clk_i) begin
		if (rst_i || state_nxt != state_r) begin
			el_cnt_r <= 12'h000;
		end else if (step_end) begin
			el_cnt_r <= el_cnt_r + 12'h001;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence trig_seq;
		trig_wr && mode_r == hsg_pkg::HSG_MODE_ONESHOT && !busy;
	endsequence
	sequence ph3_end_seq;
		state_r == hsg_pkg::HSG_ST_PH3 && phase_exit;
	endsequence

	trig_start_a: assert property (trig_seq ##0 len1_r != 9'h000 |=>
		state_r == hsg_pkg::HSG_ST_PH1 && rem_r == {2'h0, $past(len1_r)})
		else $error("trigger did not start phase 1");
	mode_off_a: assert property (mode_r == hsg_pkg::HSG_MODE_OFF && clk_if.tick |=>
		hap_sample_o == 24'h000000 && !busy)
		else $error("disabled mode produced output");
	dc_level_a: assert property (clk_if.tick && !act_r && mode_r == hsg_pkg::HSG_MODE_CONT |=>
		hap_sample_o == {$past(lvl2_r), 16'h0000})
		else $error("dc level wrong");
	ac_invert_a: assert property (clk_if.tick && act_r && half && lvl2_r != 8'h80
		&& mode_r == hsg_pkg::HSG_MODE_CONT |=> hap_sample_o == 24'(-{$past(lvl2_r), 16'h0000}))
		else $error("ac half not inverted");
	skip_zero_a: assert property (trig_seq ##0 len1_r == 9'h000 && len2_r != 11'h000 |=>
		state_r == hsg_pkg::HSG_ST_PH2)
		else $error("empty phase not skipped");
	phase_length_a: assert property (phase_exit |-> el_cnt_r + 12'h001 == {1'b0, len_cur})
		else $error("phase length wrong");
	busy_read_a: assert property (reg_rd_i && reg_addr_i == `HSG_STS_OFS |=>
		reg_rdata_o[`HSG_BUSY_BIT] == $past(busy))
		else $error("busy readback wrong");
	done_zero_a: assert property (ph3_end_seq |=> !single_pulse_busy_o
		&& (level_sel == 8'h00 || mode_r != hsg_pkg::HSG_MODE_ONESHOT) && irq_sts_r[0])
		else $error("profile end not clean");
	stray_trig_a: assert property (trig_wr && mode_r != hsg_pkg::HSG_MODE_ONESHOT |=>
		!busy && irq_sts_r[`HSG_IRQ_REFUSED_BIT])
		else $error("stray trigger acted");
	mixer_sel_a: assert property (clk_if.tick |=> mix_sample_o ==
		(($past(mixer_source_select_i) == `HSG_MIX_SRC_CODE) ? hap_sample_o : 24'h000000))
		else $error("mixer source wrong");
	clk_source_a: assert property (rate_r >= `HSG_RATE_ASYNC_MIN && fam_r == 2'h2 |->
		step_max == STEP_TICKS_44K)
		else $error("haptic clock source wrong");
endmodule // hsg_haptic_gen

// ==== logic/hsg_map.svh ====
// register offsets, field positions, reset values and timing counts of the haptic generator
// assumes: included by bare name from every file that needs a figure
`ifndef HSG_MAP_SVH
`define HSG_MAP_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define HSG_CTRL_OFS 8'h90
`define HSG_DIV_OFS 8'h91
`define HSG_LVL1_OFS 8'h92
`define HSG_LEN1_OFS 8'h93
`define HSG_LVL2_OFS 8'h94
`define HSG_LEN2_OFS 8'h95
`define HSG_LVL3_OFS 8'h96
`define HSG_LEN3_OFS 8'h97
`define HSG_STS_OFS 8'h98
`define HSG_RATE_OFS 8'h99
`define HSG_IRQ_STS_OFS 8'h9a
`define HSG_IRQ_MASK_OFS 8'h9b
// ----------------------------------------
// field positions
// ----------------------------------------
`define HSG_TRIG_BIT 4
`define HSG_MODE_LSB 2
`define HSG_ACT_BIT 1
`define HSG_BUSY_BIT 0
`define HSG_IRQ_DONE_BIT 0
`define HSG_IRQ_REFUSED_BIT 1
// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define HSG_DIV_RST 15'h7fff
`define HSG_LVL_RST 8'h00
`define HSG_LEN_SHORT_RST 9'h000
`define HSG_LEN_LONG_RST 11'h000
`define HSG_RATE_RST 4'h0
`define HSG_IRQ_RST 2'h0
`define HSG_RATE_ASYNC_MIN 4'h8
`define HSG_MIX_SRC_CODE 8'h06
// ----------------------------------------
// timing
// ----------------------------------------
`define HSG_CLK_HZ 250000000
`define HSG_FRAC_HZ 100
`define HSG_HAP_48K_HZ 6144000
`define HSG_HAP_44K_HZ 5644800
`define HSG_STEP_US 625
`define HSG_STEP_TICKS_48K (64'(`HSG_HAP_48K_HZ) * 64'(`HSG_STEP_US) / 64'd1000000)
`define HSG_STEP_TICKS_44K (64'(`HSG_HAP_44K_HZ) * 64'(`HSG_STEP_US) / 64'd1000000)
`endif

// ==== logic/hsg_pkg.sv ====
// types shared by the haptic generator modules
// assumes: nothing; offsets and counts live in hsg_map.svh
package hsg_pkg;
	typedef enum logic [1:0] {
		HSG_MODE_OFF = 2'h0,
		HSG_MODE_CONT = 2'h1,
		HSG_MODE_ONESHOT = 2'h2,
		HSG_MODE_RSVD = 2'h3
	} hsg_mode_e;
	// gray order along idle, first, second, third
	typedef enum logic [1:0] {
		HSG_ST_IDLE = 2'h0,
		HSG_ST_PH1 = 2'h1,
		HSG_ST_PH2 = 2'h3,
		HSG_ST_PH3 = 2'h2
	} hsg_state_e;
endpackage

// ==== logic/hsg_rate_tick.sv ====
// fractional divider making the 6.144 / 5.6448 mhz haptic enable from the core clock
// assumes: clk_i at the rate in hsg_map.svh, synchronous active-high reset
`timescale 1ns/100ps
`include "hsg_map.svh"
module hsg_rate_tick #(
	parameter int ACC_W = 22
) (
	input wire logic clk_i,
	input wire logic rst_i,
	hsg_clk_if.gen clk_if
);
	localparam logic [ACC_W:0] MODULUS = (ACC_W+1)'(`HSG_CLK_HZ / `HSG_FRAC_HZ);
	localparam logic [ACC_W:0] INC_48K = (ACC_W+1)'(`HSG_HAP_48K_HZ / `HSG_FRAC_HZ);
	localparam logic [ACC_W:0] INC_44K = (ACC_W+1)'(`HSG_HAP_44K_HZ / `HSG_FRAC_HZ);
	logic [ACC_W-1:0] acc_r;
	logic [ACC_W:0] sum;
	logic tick_r;
	// exact ratio, so no long-term drift of the haptic rate
	assign sum = {1'b0, acc_r} + (clk_if.fam_44k ? INC_44K : INC_48K);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc_r <= '0;
			tick_r <= 1'b0;
		end else if (sum >= MODULUS) begin
			acc_r <= ACC_W'(sum - MODULUS);
			tick_r <= 1'b1;
		end else begin
			acc_r <= ACC_W'(sum);
			tick_r <= 1'b0;
		end
	end
	assign clk_if.tick = tick_r;
	tick_spacing_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tick_r |=> !tick_r [*8])
		else $error("haptic enable too close");
endmodule // hsg_rate_tick

// ==== test/hsg_mix_model.sv ====
// output mixer stand-in: owns the source select, keeps the last mixed sample
// assumes: same clock and reset as the generator
`timescale 1ns/100ps
module hsg_mix_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] sel_code_i,
	input wire logic [23:0] mix_sample_i,
	input wire logic sample_valid_i,
	output logic [7:0] mixer_source_select_o,
	output logic [23:0] mix_last_o
);
	// select is a register of the mixer, so it moves one edge after the request
	always_ff @(posedge clk_i) begin
		if (rst_i)
			mixer_source_select_o <= 8'h00;
		else
			mixer_source_select_o <= sel_code_i;
	end
	// the mixer only takes its input on stream strobes
	always_ff @(posedge clk_i) begin
		if (rst_i)
			mix_last_o <= 24'h000000;
		else if (sample_valid_i)
			mix_last_o <= mix_sample_i;
	end
endmodule // hsg_mix_model

// ==== test/tb_top.sv ====
// self-checking bench of the haptic generator with a mixer stand-in
// assumes: short step counts (4 / 3 ticks per step) to keep the run brief
`timescale 1ns/100ps
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic main44 = 1'b0;
	logic async44 = 1'b0;
	logic [7:0] sel = 8'h06;
	logic [15:0] rdata;
	logic [7:0] msel;
	logic [23:0] smp, mix, mlast;
	logic valid, busy, irq;
	int mismatches = 0;
	int num_checks = 0;
	int cyc = 0;
	logic [15:0] seed = 16'h001f;
	localparam int S = 4;

	hsg_haptic_gen #(.STEP_TICKS_48K(12'h004), .STEP_TICKS_44K(12'h003)) i_hsg_haptic_gen (
		.clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .main_clk_44k1_i(main44),
		.async_clk_44k1_i(async44), .mixer_source_select_i(msel), .hap_sample_o(smp),
		.hap_sample_valid_o(valid), .mix_sample_o(mix), .single_pulse_busy_o(busy),
		.irq_o(irq));
	hsg_mix_model i_hsg_mix_model (.clk_i(clk), .rst_i(rst), .sel_code_i(sel),
		.mix_sample_i(mix), .sample_valid_i(valid), .mixer_source_select_o(msel),
		.mix_last_o(mlast));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	initial begin
		forever #2 clk = ~clk;
	end
	// hang guard: the run needs roughly 7k cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			mismatches++;
			give_verdict();
		end
	end
	task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic give_verdict();
		if (mismatches == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	function automatic logic [23:0] lvl(input logic [7:0] l);
		return {l, 16'h0000};
	endfunction
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [15:0] e);
		logic [15:0] d;
		rd_reg(a, d);
		check(nm, {8'h00, d}, {8'h00, e});
	endtask
	// waits for the next stream strobe; samples at the falling edge
	task automatic nxt(output logic [23:0] s);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (valid !== 1'b1 && n < 200);
		s = smp;
	endtask

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		logic [23:0] s, v;
		logic [15:0] r;
		logic [7:0] l;
		int c1, c2, c3, t0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd_chk("divider", 8'h91, 16'h7fff);
		rd_chk("level1", 8'h92, 16'h0000);
		rd_chk("length2", 8'h95, 16'h0000);
		rd_chk("busy", 8'h98, 16'h0000);
		rd_chk("hole", 8'h80, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			wr_reg(8'h93 + 8'(2 * (i % 3)), seed);
			rd_chk("length", 8'h93 + 8'(2 * (i % 3)), seed & (i % 3 == 1 ? 16'h07ff : 16'h01ff));
		end
		// divider and first level must not leak into continuous dc output
		wr_reg(8'h91, 16'h0002);
		wr_reg(8'h92, 16'h0055);
		wr_reg(8'h90, 16'h0004);
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			wr_reg(8'h94, {8'h00, seed[7:0]});
			nxt(v);
			nxt(v);
			nxt(s);
			check("dc level", s, lvl(seed[7:0]));
			check("flat", v, s);
			check("mixer", mlast, s);
		end
		@(posedge clk);
		sel <= 8'h05;
		nxt(s);
		nxt(s);
		check("mixer off", mix, 24'h000000);
		@(posedge clk);
		sel <= 8'h06;
		for (int m = 0; m < 2; m++) begin
			wr_reg(8'h90, m ? 16'h000c : 16'h0000);
			nxt(s);
			nxt(s);
			check("idle out", s, 24'h000000);
		end
		for (int k = 0; k < 2; k++) begin
			l = k ? 8'hc0 : 8'h40;
			wr_reg(8'h94, {8'h00, l});
			wr_reg(8'h90, 16'h0006);
			nxt(s);
			// first non-zero sample opens the first half of the tone
			for (int n = 0; n < 8 && s === 24'h000000; n++)
				nxt(s);
			v = s;
			check("tone sign", v, lvl(l));
			for (int n = 1; n < 6; n++) begin
				nxt(s);
				check("half period", s, n < 3 ? v : -v);
			end
			wr_reg(8'h90, 16'h0000);
		end
		wr_reg(8'h9b, 16'h0003);
		wr_reg(8'h92, 16'h0011);
		wr_reg(8'h94, 16'h00e0);
		wr_reg(8'h96, 16'h0033);
		for (int k = 0; k < 2; k++) begin
			wr_reg(8'h93, 16'h0001);
			wr_reg(8'h95, k ? 16'h0000 : 16'h0002);
			wr_reg(8'h97, 16'h0001);
			wr_reg(8'h90, 16'h0008);
			rd_reg(8'h9a, r);
			wr_reg(8'h90, 16'h0018);
			@(negedge clk);
			check("busy", {23'h0, busy}, 24'h1);
			c1 = 0;
			c2 = 0;
			c3 = 0;
			repeat ((k ? 2 : 4) * S + 2) begin
				nxt(s);
				c1 += int'(s === 24'h110000);
				c2 += int'(s === 24'he00000);
				c3 += int'(s === 24'h330000);
			end
			check("phase1 ticks", 24'(c1), 24'(S));
			check("phase2 ticks", 24'(c2), k ? 24'h0 : 24'(2 * S));
			check("phase3 ticks", 24'(c3), 24'(S));
			check("end level", s, 24'h000000);
			check("busy end", {23'h0, busy}, 24'h0);
			check("irq", {23'h0, irq}, 24'h1);
			rd_chk("done", 8'h9a, 16'h0001);
			check("irq clr", {23'h0, irq}, 24'h0);
		end
		// retrigger while busy is refused; busy shows through the register
		wr_reg(8'h95, 16'h0002);
		wr_reg(8'h90, 16'h0018);
		rd_chk("busy reg", 8'h98, 16'h0001);
		wr_reg(8'h90, 16'h0018);
		repeat (4 * S + 2) nxt(s);
		rd_chk("status", 8'h9a, 16'h0003);
		wr_reg(8'h9b, 16'h0001);
		// leave one-shot first: the trigger is judged against the mode already held
		wr_reg(8'h90, 16'h0004);
		wr_reg(8'h90, 16'h0014);
		@(negedge clk);
		check("stray trig", {23'h0, busy}, 24'h0);
		check("masked", {23'h0, irq}, 24'h0);
		rd_chk("refused", 8'h9a, 16'h0002);
		// clock source by rate setting, family by the chosen pin
		wr_reg(8'h90, 16'h0004);
		wr_reg(8'h91, 16'h2fff);
		rd_chk("divider", 8'h91, 16'h2fff);
		for (int k = 0; k < 3; k++) begin
			@(posedge clk);
			main44 <= (k == 2);
			async44 <= (k != 2);
			wr_reg(8'h99, k == 1 ? 16'h0008 : 16'h0000);
			repeat (4) nxt(s);
			t0 = cyc;
			repeat (20) nxt(s);
			t0 = cyc - t0;
			check("tick rate", 24'(t0 > (k ? 870 : 800) && t0 < (k ? 900 : 830)), 24'h1);
		end
		give_verdict();
	end
endmodule // tb_top
